// ---- hw/lpd_pkg.sv ----
/*
  Shared constants for the seven-to-one serial pixel link: lane and slot
  counts, timing counts in system clock cycles, bit map and state codes.
  Assumes both ends run on the same 50 MHz system clock.
*/
`default_nettype none

package lpd_pkg;

  // Link geometry
  localparam int LPD_LANES = 4;
  localparam int LPD_SLOTS = 7;
  localparam int LPD_WORD_W = 28;
  localparam int LPD_CNT_W = 6;

  // System clock rate, kept for reference only, not used by the derived counts
  localparam int LPD_SYS_CLK_MHZ = 50;

  // Timing counts in system clock cycles
  localparam logic [5:0] LPD_SLOT_CYCLES = 6'h04;
  localparam logic [5:0] LPD_SAMPLE_OFS = 6'(LPD_SLOT_CYCLES >> 1);
  localparam logic [5:0] LPD_PERIOD_CYCLES = 6'(LPD_SLOTS * LPD_SLOT_CYCLES);
  localparam logic [5:0] LPD_HALF_CYCLES = 6'(LPD_PERIOD_CYCLES >> 1);
  localparam logic [5:0] LPD_STOP_CYCLES = 6'(2 * LPD_PERIOD_CYCLES);
  localparam logic [5:0] LPD_PERIOD_TOL = 6'h01;
  localparam logic [2:0] LPD_LOCK_PERIODS = 3'h4;
  localparam logic [2:0] LPD_CLK_HIGH_SLOTS = 3'h4;
  localparam logic [2:0] LPD_SLOT_LAST = 3'h6;

  // Parallel word field positions
  localparam int LPD_GP_POS = 23;
  localparam int LPD_HSYNC_POS = 24;
  localparam int LPD_VSYNC_POS = 25;
  localparam int LPD_DE_POS = 26;

  // Word positions carried by the fourth lane
  localparam logic [27:0] LPD_LANE3_MASK = 28'h8830C20;

  // Word position of each lane slot, index lane*7+slot
  localparam logic [4:0] LPD_MAP [0:27] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12,
    5'h13, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A,
    5'h1B, 5'h05, 5'h0A, 5'h0B, 5'h10, 5'h11, 5'h17
  };

  typedef enum logic [2:0] {
    LPD_ST_PD = 3'b001,
    LPD_ST_HUNT = 3'b010,
    LPD_ST_LOCK = 3'b100
  } lpd_rx_state_e;

endpackage

`default_nettype wire

// ---- hw/lpd_link_if.sv ----
/*
  Link between the serializing end and the deserializing end: one
  forwarded link clock and four serial lanes (lane 3 unused when narrow).
  Assumes the testbench instantiates it and joins both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface lpd_link_if;
  logic link_clock_in;
  logic [3:0] serial_lane;

  modport tx_end (
    output link_clock_in,
    output serial_lane
  );

  modport rx_end (
    input link_clock_in,
    input serial_lane
  );
endinterface

`default_nettype wire

// ---- hw/lpd_tx_end.sv ----
/*
  Serializing end: takes a 28-bit word each link period and sends it as
  seven slots on each of four lanes with a forwarded link clock.
  Assumes the user holds i_word stable around the period start.
*/
`timescale 1ns/1ps
`default_nettype none

module lpd_tx_end
  import lpd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // User side
  input wire logic i_run,
  input wire logic [27:0] i_word,
  output logic o_word_take,
  // Link side
  lpd_link_if.tx_end link
);

  logic active_ff, nxt_active;
  logic [2:0] slot_ff, nxt_slot;
  logic [5:0] sub_ff, nxt_sub;
  logic [27:0] word_ff, nxt_word;
  logic clk_ff, nxt_clk;
  logic [3:0] lane_ff, nxt_lane;
  logic take_ff, nxt_take;
  logic launch;

  always_comb begin
    nxt_active = active_ff;
    nxt_slot = slot_ff;
    nxt_sub = sub_ff;
    nxt_word = word_ff;
    nxt_clk = clk_ff;
    nxt_lane = lane_ff;
    nxt_take = 1'b0;
    launch = 1'b0;
    if (active_ff) begin
      if (sub_ff == LPD_SLOT_CYCLES - 6'h01) begin
        nxt_sub = 6'h00;
        if (slot_ff == LPD_SLOT_LAST) begin
          nxt_slot = 3'h0;
          // Stop only at a period boundary, link clock already low
          if (i_run) begin
            launch = 1'b1;
          end else begin
            nxt_active = 1'b0;
          end
        end else begin
          nxt_slot = slot_ff + 3'h1;
          launch = 1'b1;
        end
      end else begin
        nxt_sub = sub_ff + 6'h01;
      end
    end else if (i_run) begin
      nxt_active = 1'b1;
      nxt_slot = 3'h0;
      nxt_sub = 6'h00;
      launch = 1'b1;
    end
    if (launch) begin
      if (nxt_slot == 3'h0) begin
        nxt_word = i_word;
        nxt_take = 1'b1;
      end
      // Slot n leaves at n/7 of the period
      nxt_clk = (nxt_slot < LPD_CLK_HIGH_SLOTS); // R01 R04
      for (int l = 0; l < LPD_LANES; l++) begin
        nxt_lane[l] = nxt_word[LPD_MAP[l * LPD_SLOTS + int'(nxt_slot)]]; // R02
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      active_ff <= 1'b0;
      slot_ff <= 3'h0;
      sub_ff <= 6'h00;
      word_ff <= 28'h0000000;
      clk_ff <= 1'b0;
      lane_ff <= 4'h0;
      take_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      slot_ff <= nxt_slot;
      sub_ff <= nxt_sub;
      word_ff <= nxt_word;
      clk_ff <= nxt_clk;
      lane_ff <= nxt_lane;
      take_ff <= nxt_take;
    end
  end

  assign link.link_clock_in = clk_ff;
  assign link.serial_lane = lane_ff;
  assign o_word_take = take_ff;

endmodule

`default_nettype wire

// ---- hw/lpd_rx_end.sv ----
/*
  Deserializing end: recovers the link period from the forwarded clock,
  samples seven slots per lane at slot centres and presents one parallel
  word per period with a recovered clock.
  Assumes link pins and the power-down pin are asynchronous to i_clk and
  that the far end runs on a clock of the same nominal rate.
*/
// Contract
// (R01) Transmitter keeps link clock within allowed range
// (R02) Seven bit slots per lane each period
// (R03) Sample each slot at its centre
// (R04) Transmitter launches slot n at n/7 period
// (R05) Wide variant presents 28 parallel outputs
// (R06) Narrow variant presents 21 outputs, three lanes
// (R07) Output index equals transmitter bit position
// (R08) Eighteen-bit systems leave fourth lane unconnected
// (R09) Outputs 24-26 carry sync and data valid
// (R10) Outputs change at recovered clock falling edge
// (R11) Deserialize only after lock achieved
// (R12) Power-down low forces low-power mode
// (R13) Stopped link clock freezes clock and data
// (R14) One word per recovered clock period
// (R15) Narrow variant leaves fourth-lane positions unused
`timescale 1ns/1ps
`default_nettype none

module lpd_rx_end
  import lpd_pkg::*;
#(
  parameter bit WIDE = 1'b1
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Control pin
  input wire logic i_power_down_n,
  // Link side
  lpd_link_if.rx_end link,
  // Panel side
  output logic o_recovered_clock_out,
  output logic [27:0] o_parallel_word_out,
  output logic o_locked
);

  // Bit 0 link clock, bits 1..4 lanes, bit 5 power-down
  localparam int SYNC_W = 6;
  localparam int CLK_BIT = 0;
  localparam int PD_BIT = 5;

  logic [SYNC_W-1:0] sync1_ff, sync2_ff, sync3_ff;
  logic [SYNC_W-1:0] filt_ff, nxt_filt;
  logic [SYNC_W-1:0] pin_vec;

  assign pin_vec = {i_power_down_n, link.serial_lane, link.link_clock_in};

  // A change counts once stages two and three agree
  always_comb begin
    nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff));
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      filt_ff <= '0;
    end else begin
      sync1_ff <= pin_vec;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= nxt_filt;
    end
  end

  logic edge_rise;
  logic [3:0] lane_now;
  logic pd_active;

  // Clock and lanes share the same filter delay, so phase is kept
  assign edge_rise = nxt_filt[CLK_BIT] & ~filt_ff[CLK_BIT];
  assign lane_now = nxt_filt[4:1];
  // Filtered level starts low, so power-down holds until the pin is seen high
  assign pd_active = ~nxt_filt[PD_BIT];

  lpd_rx_state_e state_ff, nxt_state;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [2:0] good_ff, nxt_good;
  logic [27:0] asm_ff, nxt_asm;
  logic [27:0] pend_ff, nxt_pend;
  logic pend_ok_ff, nxt_pend_ok;
  logic rclk_ff, nxt_rclk;
  logic [27:0] word_ff, nxt_word;
  logic locked_ff, nxt_locked;
  logic period_ok;
  logic [5:0] sub_pos;
  logic [2:0] slot_idx;
  logic [27:0] keep_mask;

  assign period_ok = (cnt_ff >= LPD_PERIOD_CYCLES - LPD_PERIOD_TOL) &&
                     (cnt_ff <= LPD_PERIOD_CYCLES + LPD_PERIOD_TOL);
  assign sub_pos = cnt_ff % LPD_SLOT_CYCLES;
  assign slot_idx = 3'(cnt_ff / LPD_SLOT_CYCLES);
  assign keep_mask = WIDE ? 28'hFFFFFFF : ~LPD_LANE3_MASK; // R05 R06 R15

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_good = good_ff;
    nxt_asm = asm_ff;
    nxt_pend = pend_ff;
    nxt_pend_ok = pend_ok_ff;
    nxt_rclk = rclk_ff;
    nxt_word = word_ff;
    nxt_locked = locked_ff;

    // Period counter restarts on every link clock rise, saturates on stop
    if (edge_rise) begin
      nxt_cnt = 6'h01;
    end else if (cnt_ff < LPD_STOP_CYCLES) begin
      nxt_cnt = cnt_ff + 6'h01;
    end

    // Slot centre sampling, stored at the transmitter bit position
    if (!edge_rise && (sub_pos == LPD_SAMPLE_OFS) && (cnt_ff < LPD_PERIOD_CYCLES)) begin // R03
      for (int l = 0; l < LPD_LANES; l++) begin
        nxt_asm[LPD_MAP[l * LPD_SLOTS + int'(slot_idx)]] = lane_now[l]; // R02 R07 R09
      end
    end

    case (state_ff)
      LPD_ST_PD: begin
        if (!pd_active) begin
          nxt_state = LPD_ST_HUNT;
          nxt_good = 3'h0;
        end
      end
      LPD_ST_HUNT: begin
        if (edge_rise) begin
          if (period_ok) begin
            if (good_ff == LPD_LOCK_PERIODS - 3'h1) begin
              nxt_state = LPD_ST_LOCK;
              nxt_locked = 1'b1;
              nxt_pend_ok = 1'b0;
              nxt_good = 3'h0;
            end else begin
              nxt_good = good_ff + 3'h1;
            end
          end else begin
            nxt_good = 3'h0;
          end
        end else if (cnt_ff == LPD_STOP_CYCLES) begin
          nxt_good = 3'h0;
        end
      end
      LPD_ST_LOCK: begin
        if (edge_rise) begin
          if (period_ok) begin
            // Word of the period just ended, shown at the coming fall
            nxt_pend = asm_ff & keep_mask; // R11 R15
            nxt_pend_ok = 1'b1;
            nxt_rclk = 1'b1; // R14
          end else begin
            nxt_state = LPD_ST_HUNT;
            nxt_locked = 1'b0;
            nxt_pend_ok = 1'b0;
          end
        end else if (cnt_ff == LPD_HALF_CYCLES && pend_ok_ff) begin
          nxt_rclk = 1'b0; // R10
          nxt_word = pend_ff; // R10 R14
          nxt_pend_ok = 1'b0;
        end else if (cnt_ff == LPD_STOP_CYCLES) begin
          // Link clock gone: clock and word simply hold
          nxt_state = LPD_ST_HUNT; // R13
          nxt_locked = 1'b0;
          nxt_pend_ok = 1'b0;
        end
      end
      default: begin
        nxt_state = LPD_ST_PD;
      end
    endcase

    // Power-down wins over the state machine, outputs forced low; period counter and slot sampling keep running
    if (pd_active) begin // R12
      nxt_state = LPD_ST_PD;
      nxt_good = 3'h0;
      nxt_pend_ok = 1'b0;
      nxt_rclk = 1'b0;
      nxt_word = 28'h0000000;
      nxt_locked = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= LPD_ST_PD;
      cnt_ff <= LPD_STOP_CYCLES;
      good_ff <= 3'h0;
      asm_ff <= 28'h0000000;
      pend_ff <= 28'h0000000;
      pend_ok_ff <= 1'b0;
      rclk_ff <= 1'b0;
      word_ff <= 28'h0000000;
      locked_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      good_ff <= nxt_good;
      asm_ff <= nxt_asm;
      pend_ff <= nxt_pend;
      pend_ok_ff <= nxt_pend_ok;
      rclk_ff <= nxt_rclk;
      word_ff <= nxt_word;
      locked_ff <= nxt_locked;
    end
  end

  assign o_recovered_clock_out = rclk_ff;
  assign o_parallel_word_out = word_ff;
  assign o_locked = locked_ff;

endmodule

`default_nettype wire

// ---- verification/lpd_properties.sv ----
/*
  Concurrent checks on the serial link and the wide deserializing end.
  Assumes it sits beside the link interface, all on one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module lpd_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Link and control
  input wire logic link_clock_in,
  input wire logic [3:0] serial_lane,
  input wire logic i_power_down_n,
  // Panel side
  input wire logic o_recovered_clock_out,
  input wire logic [27:0] o_parallel_word_out,
  input wire logic o_locked
);
  logic [7:0] hi_cnt_ff, nxt_hi_cnt, slot_cnt_ff, nxt_slot_cnt, pd_cnt_ff, nxt_pd_cnt;
  logic lc_q_ff, nxt_lc_q;

  // Saturate so a long power-down never wraps back under the limit
  always_comb begin
    nxt_hi_cnt = o_recovered_clock_out ? hi_cnt_ff + 8'h01 : 8'h00;
    nxt_slot_cnt = (link_clock_in && !lc_q_ff) ? 8'h01 : slot_cnt_ff + 8'h01;
    nxt_pd_cnt = i_power_down_n ? 8'h00 : ((pd_cnt_ff == 8'hFF) ? 8'hFF : pd_cnt_ff + 8'h01);
    nxt_lc_q = link_clock_in;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_cnt_ff <= 8'h00;
      slot_cnt_ff <= 8'h00;
      pd_cnt_ff <= 8'h00;
      lc_q_ff <= 1'b0;
    end else begin
      hi_cnt_ff <= nxt_hi_cnt;
      slot_cnt_ff <= nxt_slot_cnt;
      pd_cnt_ff <= nxt_pd_cnt;
      lc_q_ff <= nxt_lc_q;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_tx_high_time:
    assert property ($rose(link_clock_in) |-> link_clock_in[*8] ##1 link_clock_in[*8]
      ##1 !link_clock_in) else $error("Link clock high time wrong");
  a_tx_low_time:
    assert property ($fell(link_clock_in) |-> !link_clock_in[*8] ##1 !link_clock_in[*4])
      else $error("Link clock low time wrong");
  a_lane_slot_edge:
    assert property (!$stable(serial_lane) |-> $rose(link_clock_in) || slot_cnt_ff[1:0] == 2'h0)
      else $error("Lane changed inside a slot");
  a_word_on_fall:
    assert property (o_locked && !$stable(o_parallel_word_out) |-> $fell(o_recovered_clock_out))
      else $error("Word changed away from clock fall");
  a_rclk_high_time:
    assert property ($fell(o_recovered_clock_out) && o_locked |-> hi_cnt_ff == 8'h0E)
      else $error("Recovered clock high time wrong");
  a_rclk_needs_lock:
    assert property ($rose(o_recovered_clock_out) |-> o_locked)
      else $error("Recovered clock runs unlocked");
  a_hold_unlocked:
    assert property (!o_locked && !$past(o_locked) && o_parallel_word_out != 28'h0000000
      |-> $stable(o_parallel_word_out)) else $error("Word changed while unlocked");
  a_pd_quiet:
    assert property (pd_cnt_ff >= 8'h0C |-> o_parallel_word_out == 28'h0000000 && !o_locked
      && !o_recovered_clock_out) else $error("Outputs active in power-down");

  c_word_out: cover property ($fell(o_recovered_clock_out) && o_locked);
  c_lock: cover property ($rose(o_locked));
  c_unlock: cover property ($fell(o_locked));
endmodule

`default_nettype wire

// ---- verification/lpd_bench.sv ----
/*
  Bench joining both link ends, with a wide and a narrow receiver.
  Assumes the package, interface and design modules compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module lpd_bench;
  import lpd_pkg::*;
  logic i_clk, i_reset, i_run, i_power_down_n, o_word_take;
  logic [27:0] i_word, word_w, word_n;
  logic rclk_w, rclk_n, lock_w, lock_n, rclk_q;
  logic [27:0] sent[$];
  int errors, tests_run, rx_idx, n;

  lpd_link_if link();
  lpd_tx_end i_lpd_tx_end(.i_clk(i_clk), .i_reset(i_reset), .i_run(i_run),
    .i_word(i_word), .o_word_take(o_word_take), .link(link));
  lpd_rx_end #(.WIDE(1'b1)) i_lpd_rx_end(.i_clk(i_clk), .i_reset(i_reset),
    .i_power_down_n(i_power_down_n), .link(link), .o_recovered_clock_out(rclk_w),
    .o_parallel_word_out(word_w), .o_locked(lock_w));
  lpd_rx_end #(.WIDE(1'b0)) i_lpd_rx_end_narrow(.i_clk(i_clk), .i_reset(i_reset),
    .i_power_down_n(i_power_down_n), .link(link), .o_recovered_clock_out(rclk_n),
    .o_parallel_word_out(word_n), .o_locked(lock_n));
  lpd_properties i_lpd_properties(.i_clk(i_clk), .i_reset(i_reset),
    .link_clock_in(link.link_clock_in), .serial_lane(link.serial_lane),
    .i_power_down_n(i_power_down_n), .o_recovered_clock_out(rclk_w),
    .o_parallel_word_out(word_w), .o_locked(lock_w));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Returns once the word has been taken for the current period
  task automatic send(input logic [27:0] w);
    int t;
    t = 0;
    i_word = w;
    i_run = 1'b1;
    do begin @(negedge i_clk); t++; end while (o_word_take !== 1'b1 && t < 100);
    `CHK(t < 100, 1'b1)
    sent.push_back(w);
  endtask

  // Words taken before lock are lost, so align on the first one shown
  always @(negedge i_clk) begin
    if (rclk_q && !rclk_w && lock_w) begin
      if (rx_idx < 0) begin
        for (int k = sent.size() - 1; k >= 0; k--) if (sent[k] === word_w) rx_idx = k;
      end else begin
        rx_idx++;
      end
      `CHK(word_w, sent[rx_idx])
      `CHK(word_n, sent[rx_idx] & ~LPD_LANE3_MASK)
      `CHK({rclk_n, lock_n}, {rclk_w, lock_w})
    end
    rclk_q = rclk_w;
  end

  initial begin
    i_reset = 1'b1;
    i_run = 1'b0;
    i_word = 28'h0000000;
    i_power_down_n = 1'b1;
    rclk_q = 1'b0;
    rx_idx = -1;
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    for (n = 0; n < 8; n++) send(28'h1234560 + 28'(n));
    for (n = 0; n < 28; n++) send(28'h0000001 << n);
    send(28'hFFFFFFF);
    send(28'h5555555);
    send(28'hAAAAAAA);
    send(28'h0F0F0F0);
    i_run = 1'b0;
    repeat (150) @(negedge i_clk);
    `CHK(word_w, sent[sent.size() - 2])
    `CHK({lock_w, rx_idx}, {1'b0, sent.size() - 2})
    sent.delete();
    rx_idx = -1;
    for (n = 0; n < 3; n++) send(28'h3C3C3C0 + 28'(n));
    i_power_down_n = 1'b0;
    for (n = 0; n < 2; n++) send(28'h4B4B4B0 + 28'(n));
    `CHK({word_w, rclk_w, lock_w}, 30'h00000000)
    i_power_down_n = 1'b1;
    for (n = 0; n < 12; n++) send(28'h7654320 + 28'(n));
    `CHK({lock_w, rx_idx}, {1'b1, sent.size() - 3})
    i_run = 1'b0;
    repeat (40) @(negedge i_clk);
    `CHK(word_w, sent[sent.size() - 2])
    // Short gap then restart: the long period must drop lock, word holds
    send(28'h1111111);
    repeat (8) @(negedge i_clk);
    `CHK({lock_w, word_w}, {1'b0, sent[sent.size() - 3]})
    i_run = 1'b0;
    repeat (40) @(negedge i_clk);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
